/* File: hdl/rst_seq_pkg.sv */
// Constants, field layout and state types shared by the reset sequencer files.
// Assumes a single 200 MHz system clock; all times are turned into cycle counts here.
package rst_seq_pkg;

  // Clock and glitch filter timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int GLITCH_NS = 12;
  // Least time, so round up: a low shorter than this never passes
  localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycles to ignore the pin after our own drive is released
  localparam int SETTLE_CYCLES = GLITCH_CYCLES + 1;

  // Debug line framing
  localparam int BREAK_BITS = 9;
  localparam int FRAME_DATA_BITS = 8;

  // Reset cause register layout
  localparam int CAUSE_W = 8;
  localparam int CAUSE_POWER_ON_BIT = 7;
  localparam int CAUSE_STOP_RECOVERY_BIT = 6;
  localparam int CAUSE_WATCHDOG_BIT = 5;
  localparam int CAUSE_EXTERNAL_PIN_BIT = 4;
  localparam int CAUSE_BROWNOUT_BIT = 0;
  localparam logic [CAUSE_W-1:0] CAUSE_UPPER_MASK = 8'hF0;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET_VALUE = 8'h80;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 8'h00;

  // Watchdog control register, write-only, shares the cause register address
  localparam logic [CAUSE_W-1:0] WATCHDOG_CTL_RESET_VALUE = 8'h00;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PIN_WAIT, SEQ_HOLD, SEQ_SETTLE} seq_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage : rst_seq_pkg

/* File: hdl/reset_source_if.sv */
// Carrier between the reset sequencer core and its two front-end modules.
// All signals are synchronous to the system clock and driven from flip-flops.
`timescale 1ns/1ps
interface reset_source_if;
  logic pin_low;
  logic break_p;
  logic frame_p;
  logic collision_p;

  modport filt (output pin_low);
  modport mon (output break_p, output frame_p, output collision_p);
  modport core (input pin_low, input break_p, input frame_p, input collision_p);
endinterface : reset_source_if

/* File: hdl/reset_pin_filter.sv */
// Glitch filter for the reset pin: reports a low only once it has lasted.
// Assumes the pin input is already synchronous to the system clock.
`timescale 1ns/1ps
module reset_pin_filter
  import rst_seq_pkg::*;
#(
  parameter int FILTER_CYCLES = GLITCH_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  reset_source_if.filt src
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(FILTER_CYCLES - 1);

  logic [CW-1:0] low_cnt_reg;

  // Count consecutive low samples; any high sample restarts the count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_reg <= '0;
      src.pin_low <= 1'b0;
    end else if (pin_i) begin
      low_cnt_reg <= '0;
      src.pin_low <= 1'b0;
    end else if (low_cnt_reg == LIMIT) begin
      src.pin_low <= 1'b1;
    end else begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

endmodule : reset_pin_filter

/* File: hdl/debug_line_monitor.sv */
// Watches the single-wire debug line for break, framing error and collision.
// Assumes the debug unit reports its own transmit enable and bit level as inputs.
`timescale 1ns/1ps
module debug_line_monitor
  import rst_seq_pkg::*;
#(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic line_i,
  input wire logic tx_en_i,
  input wire logic tx_bit_i,
  reset_source_if.mon src
);

  localparam int BREAK_CYCLES = BREAK_BITS * BIT_CYCLES;
  localparam int BW = $clog2(BREAK_CYCLES + 1);
  localparam int TW = $clog2(BIT_CYCLES + 1);
  localparam logic [BW-1:0] BREAK_LIMIT = BW'(BREAK_CYCLES);
  localparam logic [TW-1:0] HALF_BIT = TW'(BIT_CYCLES / 2 - 1);
  localparam logic [TW-1:0] FULL_BIT = TW'(BIT_CYCLES - 1);
  localparam logic [3:0] LAST_DATA = 4'(FRAME_DATA_BITS - 1);

  logic [BW-1:0] low_cnt_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic [3:0] bit_idx_reg;
  rx_state_t rx_state_reg;
  logic line_d_reg;
  logic clash_d_reg;
  logic sample_en;
  logic clash;

  // Bit-rate divider gives a one-cycle sample enable in the middle of each bit
  assign sample_en = (rx_state_reg != RX_IDLE) && (tick_cnt_reg == '0);
  // Line pulled low while the debug unit sends a high bit: someone else drives it
  assign clash = tx_en_i && tx_bit_i && !line_i;

  // Break: line held low for nine whole bit times, reported once per low period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_reg <= '0;
      src.break_p <= 1'b0;
    end else begin
      src.break_p <= 1'b0;
      if (line_i) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg != BREAK_LIMIT) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
        src.break_p <= (low_cnt_reg == BREAK_LIMIT - 1'b1);
      end
    end
  end

  // Receiver framing: start bit, eight data bits, then the stop bit must be high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_reg <= RX_IDLE;
      tick_cnt_reg <= '0;
      bit_idx_reg <= '0;
      line_d_reg <= 1'b1;
      src.frame_p <= 1'b0;
    end else begin
      line_d_reg <= line_i;
      src.frame_p <= 1'b0;
      if (rx_state_reg == RX_IDLE) begin
        if (line_d_reg && !line_i) begin
          rx_state_reg <= RX_START;
          tick_cnt_reg <= HALF_BIT;
        end
      end else if (!sample_en) begin
        tick_cnt_reg <= tick_cnt_reg - 1'b1;
      end else begin
        tick_cnt_reg <= FULL_BIT;
        case (rx_state_reg)
          RX_START: begin
            // A start bit that has gone high again was only noise
            rx_state_reg <= line_i ? RX_IDLE : RX_DATA;
            bit_idx_reg <= '0;
          end
          RX_DATA: begin
            bit_idx_reg <= bit_idx_reg + 1'b1;
            if (bit_idx_reg == LAST_DATA) begin
              rx_state_reg <= RX_STOP;
            end
          end
          default: begin
            src.frame_p <= !line_i;
            rx_state_reg <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Collision reported on its first cycle only, so a long clash gives one event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clash_d_reg <= 1'b0;
      src.collision_p <= 1'b0;
    end else begin
      clash_d_reg <= clash;
      src.collision_p <= clash && !clash_d_reg;
    end
  end

endmodule : debug_line_monitor

/* File: hdl/reset_and_stop_recovery.sv */
// Reset sequencer: gathers reset sources, drives the system reset and the pin,
// and keeps the reset cause register shared with the watchdog control register.
// Assumes all inputs are synchronous to CLOCK_I; the pin has an external pull-up.
//
// Summary of operation
// - Reset from pin, power-on, watchdog, halt exit, brownout.
// - Reset pin is both request input and indicator.
// - Pin low during halt gives full reset.
// - Ignore pin lows shorter than about 12 ns.
// - Pin wake from halt sets external pin flag.
// - Nine low bit times on debug line: debug reset.
// - Low stop bit on debug line: debug reset.
// - Debug transmit collision: debug reset.
// - Debug reset during halt gives system reset.
// - Debug unit stays out of debug-caused reset.
// - Debug reset from halt sets power-on flag.
// - Cause register read-only; read clears upper four bits.
// - Reads give cause, writes go to watchdog control.
`timescale 1ns/1ps
module reset_and_stop_recovery
  import rst_seq_pkg::*;
#(
  parameter int RESET_HOLD_CYCLES = 64,
  parameter int DEBUG_BIT_CYCLES = 16
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic POWER_ON_I,
  input wire logic WATCHDOG_TIMEOUT_I,
  input wire logic STOP_EXIT_I,
  input wire logic SUPPLY_BROWNOUT_WARNING_I,
  input wire logic HALT_I,
  input wire logic RESET_PIN_I,
  output logic RESET_PIN_O,
  output logic RESET_PIN_OE_O,
  input wire logic DEBUG_SERIAL_PIN_I,
  input wire logic DEBUG_TX_EN_I,
  input wire logic DEBUG_TX_BIT_I,
  input wire logic SHARED_SEL_I,
  input wire logic SHARED_RD_I,
  input wire logic SHARED_WR_I,
  input wire logic [CAUSE_W-1:0] SHARED_WDATA_I,
  output logic [CAUSE_W-1:0] RESET_CAUSE_RDATA_O,
  output logic [CAUSE_W-1:0] WATCHDOG_CTL_O,
  output logic WATCHDOG_CTL_WR_O,
  output logic SYS_RESET_N_O,
  output logic ON_CHIP_DEBUG_UNIT_RESET_N_O,
  output logic DEBUG_RESET_O
);

  localparam int HW = $clog2(RESET_HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(RESET_HOLD_CYCLES - 1);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES - 1);

  reset_source_if src_bus ();

  seq_state_t seq_state_reg;
  seq_state_t seq_state_next;
  logic [HW-1:0] hold_cnt_reg;
  logic [SW-1:0] settle_cnt_reg;
  logic [CAUSE_W-1:0] cause_reg;
  logic [CAUSE_W-1:0] event_cause;
  logic [CAUSE_W-1:0] rdata_reg;
  logic [CAUSE_W-1:0] watchdog_ctl_reg;
  logic watchdog_wr_reg;
  logic drive_pin_reg;
  logic keep_debug_reg;
  logic sys_reset_n_reg;
  logic debug_unit_reset_n_reg;
  logic debug_reset_reg;
  logic pin_oe_reg;
  logic debug_err;
  logic debug_in_halt;
  logic internal_req;
  logic pin_req;
  logic start_internal;
  logic restart_hold;
  logic in_reset_next;
  logic rd_hit;
  logic wr_hit;

  // Pin glitch filter front end
  reset_pin_filter #(
    .FILTER_CYCLES(GLITCH_CYCLES)
  ) u_pin_filter (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .pin_i(RESET_PIN_I),
    .src(src_bus.filt)
  );

  // Debug line error detection front end
  debug_line_monitor #(
    .BIT_CYCLES(DEBUG_BIT_CYCLES)
  ) u_debug_monitor (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .line_i(DEBUG_SERIAL_PIN_I),
    .tx_en_i(DEBUG_TX_EN_I),
    .tx_bit_i(DEBUG_TX_BIT_I),
    .src(src_bus.mon)
  );

  // Source collection; a debug error only reaches the system while halted
  assign debug_err = src_bus.break_p || src_bus.frame_p || src_bus.collision_p;
  assign debug_in_halt = debug_err && HALT_I;
  assign internal_req = POWER_ON_I || WATCHDOG_TIMEOUT_I || STOP_EXIT_I
                        || SUPPLY_BROWNOUT_WARNING_I || debug_in_halt;
  assign pin_req = src_bus.pin_low;
  assign start_internal = (seq_state_reg == SEQ_IDLE) && internal_req;
  // A fresh internal source during the hold restarts it, so no cause is lost
  assign restart_hold = (seq_state_reg == SEQ_HOLD) && internal_req;
  assign rd_hit = SHARED_SEL_I && SHARED_RD_I;
  assign wr_hit = SHARED_SEL_I && SHARED_WR_I;

  // Cause bits of whatever source fires this cycle
  always_comb begin
    event_cause = CAUSE_NONE;
    event_cause[CAUSE_POWER_ON_BIT] = POWER_ON_I || debug_in_halt;
    event_cause[CAUSE_WATCHDOG_BIT] = WATCHDOG_TIMEOUT_I;
    event_cause[CAUSE_BROWNOUT_BIT] = SUPPLY_BROWNOUT_WARNING_I;
    event_cause[CAUSE_STOP_RECOVERY_BIT] = STOP_EXIT_I || (HALT_I && (pin_req || debug_err));
    if ((seq_state_reg == SEQ_IDLE) && !internal_req) begin
      event_cause[CAUSE_EXTERNAL_PIN_BIT] = pin_req;
    end
  end

  // Sequencer next state: internal sources win over a pin request in the same cycle
  always_comb begin
    seq_state_next = seq_state_reg;
    case (seq_state_reg)
      SEQ_IDLE: begin
        if (internal_req) begin
          seq_state_next = SEQ_HOLD;
        end else if (pin_req) begin
          seq_state_next = SEQ_PIN_WAIT;
        end
      end
      SEQ_PIN_WAIT: begin
        // Stay in reset until the other party lets the pin go
        if (!pin_req) begin
          seq_state_next = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!internal_req && (hold_cnt_reg == HOLD_LAST)) begin
          seq_state_next = SEQ_SETTLE;
        end
      end
      default: begin
        if (settle_cnt_reg == SETTLE_LAST) begin
          seq_state_next = SEQ_IDLE;
        end
      end
    endcase
  end

  assign in_reset_next = (seq_state_next == SEQ_PIN_WAIT) || (seq_state_next == SEQ_HOLD);

  // State register; power-up starts in the hold as a power-on reset
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      seq_state_reg <= SEQ_HOLD;
    end else begin
      seq_state_reg <= seq_state_next;
    end
  end

  // Hold and settle counters
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hold_cnt_reg <= '0;
      settle_cnt_reg <= '0;
    end else begin
      if ((seq_state_reg != SEQ_HOLD) || restart_hold) begin
        hold_cnt_reg <= '0;
      end else if (hold_cnt_reg != HOLD_LAST) begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end
      if (seq_state_reg != SEQ_SETTLE) begin
        settle_cnt_reg <= '0;
      end else begin
        settle_cnt_reg <= settle_cnt_reg + 1'b1;
      end
    end
  end

  // Whether we drive the pin and whether the debug unit is spared
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      drive_pin_reg <= 1'b1;
      keep_debug_reg <= 1'b0;
    end else if (start_internal) begin
      drive_pin_reg <= 1'b1;
      keep_debug_reg <= (event_cause == ((CAUSE_W)'(1) << CAUSE_POWER_ON_BIT
                         | (CAUSE_W)'(1) << CAUSE_STOP_RECOVERY_BIT)) && !POWER_ON_I;
    end else if (restart_hold) begin
      // Any other source joining in makes it a normal reset for everyone
      keep_debug_reg <= keep_debug_reg && !POWER_ON_I && !WATCHDOG_TIMEOUT_I
                        && !STOP_EXIT_I && !SUPPLY_BROWNOUT_WARNING_I;
    end else if ((seq_state_reg == SEQ_IDLE) && pin_req) begin
      drive_pin_reg <= 1'b0;
      keep_debug_reg <= 1'b0;
    end
  end

  // Registered reset outputs; all but DEBUG_RESET_O are derived from the next state so they align with it
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sys_reset_n_reg <= 1'b0;
      debug_unit_reset_n_reg <= 1'b0;
      pin_oe_reg <= 1'b1;
      debug_reset_reg <= 1'b0;
    end else begin
      sys_reset_n_reg <= !in_reset_next;
      debug_unit_reset_n_reg <= !in_reset_next || (start_internal ? (debug_in_halt
                                && !POWER_ON_I && !WATCHDOG_TIMEOUT_I && !STOP_EXIT_I
                                && !SUPPLY_BROWNOUT_WARNING_I) : keep_debug_reg);
      // Pin is released as the hold ends; settle then masks the slow rise
      pin_oe_reg <= (seq_state_next == SEQ_HOLD)
                    && (start_internal || (drive_pin_reg && seq_state_reg == SEQ_HOLD));
      debug_reset_reg <= debug_err;
    end
  end

  // Cause register: a new reset replaces it, a read clears the upper half.
  // A cause arriving in the same cycle as a read wins over the clear.
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cause_reg <= CAUSE_RESET_VALUE;
    end else if (start_internal || ((seq_state_reg == SEQ_IDLE) && pin_req)) begin
      cause_reg <= event_cause;
    end else if (restart_hold) begin
      cause_reg <= (rd_hit ? (cause_reg & ~CAUSE_UPPER_MASK) : cause_reg) | event_cause;
    end else if (rd_hit) begin
      cause_reg <= cause_reg & ~CAUSE_UPPER_MASK;
    end
  end

  // Shared address: reads return the cause, writes land in watchdog control
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_reg <= CAUSE_NONE;
      watchdog_ctl_reg <= WATCHDOG_CTL_RESET_VALUE;
      watchdog_wr_reg <= 1'b0;
    end else begin
      watchdog_wr_reg <= wr_hit;
      if (rd_hit) begin
        rdata_reg <= cause_reg;
      end
      if (wr_hit) begin
        watchdog_ctl_reg <= SHARED_WDATA_I;
      end
    end
  end

  // Pin data is always low; only the enable moves, as for an open-drain pin
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RESET_PIN_O <= 1'b0;
    end else begin
      RESET_PIN_O <= 1'b0;
    end
  end

  assign RESET_PIN_OE_O = pin_oe_reg;
  assign RESET_CAUSE_RDATA_O = rdata_reg;
  assign WATCHDOG_CTL_O = watchdog_ctl_reg;
  assign WATCHDOG_CTL_WR_O = watchdog_wr_reg;
  assign SYS_RESET_N_O = sys_reset_n_reg;
  assign ON_CHIP_DEBUG_UNIT_RESET_N_O = debug_unit_reset_n_reg;
  assign DEBUG_RESET_O = debug_reset_reg;

endmodule : reset_and_stop_recovery

/* File: test/reset_and_stop_recovery_asserts.sv */
// Checker for the reset sequencer, watching only the top module ports.
// Assumes one clock domain; the hold count is handed on by the bind.
`timescale 1ns/1ps
module reset_and_stop_recovery_asserts
  import rst_seq_pkg::*;
#(
  parameter int RESET_HOLD_CYCLES = 64,
  parameter int DEBUG_BIT_CYCLES = 16
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic POWER_ON_I,
  input wire logic WATCHDOG_TIMEOUT_I,
  input wire logic STOP_EXIT_I,
  input wire logic SUPPLY_BROWNOUT_WARNING_I,
  input wire logic HALT_I,
  input wire logic RESET_PIN_I,
  input wire logic RESET_PIN_O,
  input wire logic RESET_PIN_OE_O,
  input wire logic DEBUG_SERIAL_PIN_I,
  input wire logic DEBUG_TX_EN_I,
  input wire logic DEBUG_TX_BIT_I,
  input wire logic SHARED_SEL_I,
  input wire logic SHARED_RD_I,
  input wire logic SHARED_WR_I,
  input wire logic [CAUSE_W-1:0] SHARED_WDATA_I,
  input wire logic [CAUSE_W-1:0] RESET_CAUSE_RDATA_O,
  input wire logic [CAUSE_W-1:0] WATCHDOG_CTL_O,
  input wire logic WATCHDOG_CTL_WR_O,
  input wire logic SYS_RESET_N_O,
  input wire logic ON_CHIP_DEBUG_UNIT_RESET_N_O,
  input wire logic DEBUG_RESET_O
);
  logic src;
  logic coll;
  logic rdq;
  int unsigned up_cnt;
  int unsigned oe_cnt;

  // Internal sources, debug collision and a quiet read
  assign src = POWER_ON_I | WATCHDOG_TIMEOUT_I | STOP_EXIT_I | SUPPLY_BROWNOUT_WARNING_I;
  assign coll = DEBUG_TX_EN_I & DEBUG_TX_BIT_I & ~DEBUG_SERIAL_PIN_I;
  assign rdq = SHARED_SEL_I & SHARED_RD_I & ~src & RESET_PIN_I & ~HALT_I & (up_cnt >= 1);

  // Cycles since release; the settle window is excluded by asking for 8
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) up_cnt <= 0;
    else if (!SYS_RESET_N_O) up_cnt <= 0;
    else if (up_cnt < 1000) up_cnt <= up_cnt + 1;
  end

  // Cycles the pin has been driven
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) oe_cnt <= 0;
    else if (!RESET_PIN_OE_O) oe_cnt <= 0;
    else if (oe_cnt < 1000) oe_cnt <= oe_cnt + 1;
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  chk_pin_drive: assert property (
    RESET_PIN_OE_O |-> !RESET_PIN_O && !SYS_RESET_N_O) else $error("pin driven outside reset");
  chk_src_taken: assert property (
    src && up_cnt >= 8 |=> !SYS_RESET_N_O && RESET_PIN_OE_O) else $error("source not taken");
  chk_hold_len: assert property (
    $fell(RESET_PIN_OE_O) |-> oe_cnt >= RESET_HOLD_CYCLES) else $error("pin released early");
  chk_ctl_write: assert property (
    SHARED_SEL_I && SHARED_WR_I |=> WATCHDOG_CTL_WR_O && WATCHDOG_CTL_O == $past(SHARED_WDATA_I))
    else $error("control write lost");
  chk_read_clear: assert property (
    rdq ##1 rdq |=> RESET_CAUSE_RDATA_O[7:4] == 4'h0) else $error("read did not clear");
  chk_dbg_unit: assert property (
    !ON_CHIP_DEBUG_UNIT_RESET_N_O |-> !SYS_RESET_N_O) else $error("debug unit reset alone");
  chk_halt_debug: assert property (
    $rose(DEBUG_RESET_O) && $past(HALT_I) && $past(HALT_I, 2) && $past(up_cnt, 3) >= 8
    |-> ##[0:2] !SYS_RESET_N_O) else $error("debug in halt gave no reset");
  chk_collision: assert property (
    $rose(coll) |-> ##[1:4] DEBUG_RESET_O) else $error("collision not reported");
  chk_glitch_skip: assert property (
    (up_cnt >= 8 && !src && RESET_PIN_I) ##1 (!RESET_PIN_I && !src)[*2] ##1 (RESET_PIN_I && !src)
    |=> SYS_RESET_N_O[*3]) else $error("glitch caused reset");
  chk_pin_halt: assert property (
    (HALT_I && !src && up_cnt >= 8 && !RESET_PIN_I) ##1 (!RESET_PIN_I && !src)[*4]
    |-> ##[0:3] !SYS_RESET_N_O) else $error("pin low in halt gave no reset");

  cov_halt_debug: cover property ($rose(DEBUG_RESET_O) && HALT_I);
  cov_pin_reset: cover property ($fell(SYS_RESET_N_O) && !RESET_PIN_OE_O);
  cov_double_read: cover property (rdq ##1 rdq);
endmodule : reset_and_stop_recovery_asserts

bind reset_and_stop_recovery reset_and_stop_recovery_asserts #(
  .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES), .DEBUG_BIT_CYCLES(DEBUG_BIT_CYCLES)
) u_chk (
  .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .POWER_ON_I(POWER_ON_I),
  .WATCHDOG_TIMEOUT_I(WATCHDOG_TIMEOUT_I), .STOP_EXIT_I(STOP_EXIT_I),
  .SUPPLY_BROWNOUT_WARNING_I(SUPPLY_BROWNOUT_WARNING_I), .HALT_I(HALT_I),
  .RESET_PIN_I(RESET_PIN_I), .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE_O(RESET_PIN_OE_O),
  .DEBUG_SERIAL_PIN_I(DEBUG_SERIAL_PIN_I), .DEBUG_TX_EN_I(DEBUG_TX_EN_I),
  .DEBUG_TX_BIT_I(DEBUG_TX_BIT_I), .SHARED_SEL_I(SHARED_SEL_I), .SHARED_RD_I(SHARED_RD_I),
  .SHARED_WR_I(SHARED_WR_I), .SHARED_WDATA_I(SHARED_WDATA_I),
  .RESET_CAUSE_RDATA_O(RESET_CAUSE_RDATA_O), .WATCHDOG_CTL_O(WATCHDOG_CTL_O),
  .WATCHDOG_CTL_WR_O(WATCHDOG_CTL_WR_O), .SYS_RESET_N_O(SYS_RESET_N_O),
  .ON_CHIP_DEBUG_UNIT_RESET_N_O(ON_CHIP_DEBUG_UNIT_RESET_N_O), .DEBUG_RESET_O(DEBUG_RESET_O)
);

/* File: test/reset_far_side_model.sv */
// Far side model: external reset circuitry with a pull-up, and a serial debug host.
// Assumes its tasks are called just after a rising edge of the system clock.
`timescale 1ns/1ps
module reset_far_side_model #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic pin_oe_i,
  input wire logic dev_tx_en_i,
  input wire logic dev_tx_bit_i,
  output logic pin_o,
  output logic dbg_line_o
);
  logic ext_low = 1'b0;
  logic host_low = 1'b0;

  // Both wires are pulled up; any party pulling low wins, so no stale level lingers
  assign pin_o = ~(pin_oe_i | ext_low);
  assign dbg_line_o = ~(host_low | (dev_tx_en_i & ~dev_tx_bit_i));

  // A request shorter than the filter is a deliberate glitch
  task automatic pull_pin(input int cycles);
    ext_low <= 1'b1;
    repeat (cycles) @(posedge clk_i);
    ext_low <= 1'b0;
  endtask : pull_pin

  // Start bit, eight data bits first bit lowest, then the given stop level
  task automatic send_frame(input logic [7:0] data, input logic stop);
    logic [9:0] bits;
    bits = {stop, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_low <= ~bits[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
    end
    host_low <= 1'b0;
  endtask : send_frame

  // Holds the line low for whole bit times
  task automatic send_break(input int nbits);
    host_low <= 1'b1;
    repeat (nbits * BIT_CYCLES) @(posedge clk_i);
    host_low <= 1'b0;
  endtask : send_break
endmodule : reset_far_side_model

/* File: test/reset_and_stop_recovery_bench.sv */
// Self-checking bench for the reset sequencer with a short hold and bit time.
// Assumes the far side model owns both pins; inputs change on rising edges.
`timescale 1ns/1ps
module reset_and_stop_recovery_bench
  import rst_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] src_vec = 4'h0;
  logic halt = 1'b0;
  logic tx_en = 1'b0;
  logic tx_bit = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic pin;
  logic dbg_line;
  logic pin_oe;
  logic [7:0] rdata;
  logic [7:0] ctl;
  logic ctl_wr;
  logic sys_rst_n;
  logic dbg_unit_rst_n;
  logic dbg_rst;
  int mismatches = 0;
  int num_checks = 0;
  int dbg_pulses = 0;
  localparam int HOLD_T = 8, BIT_T = 4;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Debug error pulses are counted so slow scenarios cannot miss them
  always @(posedge clk) if (dbg_rst === 1'b1) dbg_pulses <= dbg_pulses + 1;

  reset_and_stop_recovery #(.RESET_HOLD_CYCLES(HOLD_T), .DEBUG_BIT_CYCLES(BIT_T)) u_dut (
    .CLOCK_I(clk), .RESETN_I(rst_n), .POWER_ON_I(src_vec[3]), .WATCHDOG_TIMEOUT_I(src_vec[0]),
    .STOP_EXIT_I(src_vec[1]), .SUPPLY_BROWNOUT_WARNING_I(src_vec[2]), .HALT_I(halt),
    .RESET_PIN_I(pin), .RESET_PIN_O(), .RESET_PIN_OE_O(pin_oe), .DEBUG_SERIAL_PIN_I(dbg_line),
    .DEBUG_TX_EN_I(tx_en), .DEBUG_TX_BIT_I(tx_bit), .SHARED_SEL_I(sel), .SHARED_RD_I(rd),
    .SHARED_WR_I(wr), .SHARED_WDATA_I(wdata), .RESET_CAUSE_RDATA_O(rdata),
    .WATCHDOG_CTL_O(ctl), .WATCHDOG_CTL_WR_O(ctl_wr), .SYS_RESET_N_O(sys_rst_n),
    .ON_CHIP_DEBUG_UNIT_RESET_N_O(dbg_unit_rst_n), .DEBUG_RESET_O(dbg_rst)
  );

  reset_far_side_model #(.BIT_CYCLES(BIT_T)) u_far (
    .clk_i(clk), .pin_oe_i(pin_oe), .dev_tx_en_i(tx_en), .dev_tx_bit_i(tx_bit),
    .pin_o(pin), .dbg_line_o(dbg_line)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : check

  // Bounded wait for the system reset to be released
  task automatic wait_sys();
    int k;
    k = 0;
    while (sys_rst_n !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (sys_rst_n !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_sys

  // Holds the read strobe for n back-to-back reads, returns the last result
  task automatic read_cause(input int n, output logic [7:0] v);
    @(posedge clk);
    sel <= 1'b1;
    rd <= 1'b1;
    repeat (n) @(posedge clk);
    sel <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    v = rdata;
  endtask : read_cause

  task automatic t_power_up();
    logic [7:0] v;
    @(negedge clk);
    check(8'(pin_oe), 8'h1);
    check(8'(sys_rst_n), 8'h0);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_sys();
    check(8'(pin_oe), 8'h0);
    read_cause(1, v);
    check(v, CAUSE_RESET_VALUE);
    read_cause(2, v);
    check(v, CAUSE_RESET_VALUE & ~CAUSE_UPPER_MASK);
  endtask : t_power_up

  // Each internal source alone: watchdog, halt exit, brownout, power-on
  task automatic t_sources();
    logic [7:0] v;
    int pos [4] = '{CAUSE_WATCHDOG_BIT, CAUSE_STOP_RECOVERY_BIT, CAUSE_BROWNOUT_BIT,
                    CAUSE_POWER_ON_BIT};
    for (int i = 0; i < 4; i++) begin
      repeat (8) @(posedge clk);
      src_vec <= 4'h1 << i;
      @(posedge clk);
      src_vec <= 4'h0;
      @(negedge clk);
      check(8'(sys_rst_n), 8'h0);
      check(8'(pin_oe), 8'h1);
      wait_sys();
      read_cause(1, v);
      check(v, 8'h01 << pos[i]);
    end
  endtask : t_sources

  task automatic t_pin_halt();
    logic [7:0] v;
    repeat (8) @(posedge clk);
    halt <= 1'b1;
    u_far.pull_pin(2);
    repeat (6) @(negedge clk);
    check(8'(sys_rst_n), 8'h1);
    @(posedge clk);
    u_far.pull_pin(5);
    halt <= 1'b0;
    @(negedge clk);
    check(8'(sys_rst_n), 8'h0);
    wait_sys();
    read_cause(1, v);
    check(v, (8'h01 << CAUSE_EXTERNAL_PIN_BIT) | (8'h01 << CAUSE_STOP_RECOVERY_BIT));
  endtask : t_pin_halt

  task automatic t_debug_halt();
    logic [7:0] v;
    repeat (8) @(posedge clk);
    halt <= 1'b1;
    u_far.send_break(10);
    @(negedge clk);
    check(8'(dbg_pulses), 8'h1);
    check(8'(sys_rst_n), 8'h0);
    check(8'(dbg_unit_rst_n), 8'h1);
    @(posedge clk);
    halt <= 1'b0;
    wait_sys();
    read_cause(1, v);
    check(v, (8'h01 << CAUSE_POWER_ON_BIT) | (8'h01 << CAUSE_STOP_RECOVERY_BIT));
  endtask : t_debug_halt

  // Awake: bad stop bit, good frame, then a collision; none resets the system
  task automatic t_debug_awake();
    repeat (8) @(posedge clk);
    u_far.send_frame(8'h5A, 1'b0);
    repeat (8) @(posedge clk);
    check(8'(dbg_pulses), 8'h3);
    u_far.send_frame(8'hA5, 1'b1);
    repeat (8) @(posedge clk);
    check(8'(dbg_pulses), 8'h3);
    tx_en <= 1'b1;
    tx_bit <= 1'b1;
    u_far.send_break(1);
    tx_en <= 1'b0;
    repeat (8) @(posedge clk);
    check(8'(dbg_pulses), 8'h4);
    check(8'(sys_rst_n), 8'h1);
  endtask : t_debug_awake

  // A control write lands in the control register and leaves the cause alone
  task automatic t_shared();
    logic [7:0] v;
    repeat (48) @(posedge clk);
    src_vec <= 4'h1;
    @(posedge clk);
    src_vec <= 4'h0;
    @(negedge clk);
    wait_sys();
    @(posedge clk);
    sel <= 1'b1;
    wr <= 1'b1;
    wdata <= 8'hC3;
    @(posedge clk);
    sel <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
    check(8'(ctl_wr), 8'h1);
    check(ctl, 8'hC3);
    @(negedge clk);
    check(8'(ctl_wr), 8'h0);
    read_cause(1, v);
    check(v, 8'h01 << CAUSE_WATCHDOG_BIT);
    read_cause(1, v);
    check(v, CAUSE_NONE);
  endtask : t_shared

  initial begin
    t_power_up();
    t_sources();
    t_pin_halt();
    t_debug_halt();
    t_debug_awake();
    t_shared();
    report_and_stop();
  end
endmodule : reset_and_stop_recovery_bench
